// file: ipvr_pkg.sv
/*
 * Package of the interrupt priority vector resolver: register offsets, field positions,
 * reset values, source indices, vector addresses and bundled types.
 * Assumes a single 10 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package ipvr_pkg;
    // Register byte offsets on the register bus.
    localparam logic [15:0] PRIO_MISC_OFS = 16'h103C;
    localparam logic [15:0] CORE_CTRL_OFS = 16'h1040;
    localparam logic [15:0] PEND_STAT_OFS = 16'h1044;
    localparam logic [15:0] SCI_STAT_OFS = 16'h1048;
    localparam logic [15:0] SCI_DATA_OFS = 16'h104C;

    // Fields of the priority select and mode register.
    localparam int BOOT_VIS_BIT = 7;
    localparam int SMODE_BIT = 6;
    localparam int MODEA_BIT = 5;
    localparam int RDVIS_BIT = 4;
    localparam int PSEL_LSB = 0;
    localparam logic [3:0] PSEL_RESET = 4'h6;
    localparam logic [3:0] PSEL_RSVD = 4'h5;
    // Edges after reset release before the mode straps are latched.
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // Fields of the core control register.
    localparam int GMASK_BIT = 0;
    localparam int XMASK_BIT = 1;
    localparam int CLKMON_BIT = 2;
    localparam int WDOG_DIS_BIT = 3;

    // Field of the serial status register.
    localparam int RXFULL_BIT = 5;

    // Source indices, highest default rank first.
    localparam int NUM_SRC = 21;
    localparam int NUM_MASKABLE = 15;
    localparam logic [4:0] SRC_RESET = 5'h00;
    localparam logic [4:0] SRC_CLKFAIL = 5'h01;
    localparam logic [4:0] SRC_WDOG = 5'h02;
    localparam logic [4:0] SRC_NMI = 5'h03;
    localparam logic [4:0] SRC_ILLOP = 5'h04;
    localparam logic [4:0] SRC_SWI = 5'h05;
    localparam logic [4:0] SRC_MASK0 = 5'h06;
    localparam logic [4:0] SRC_NONE = 5'h1F;

    // Maskable source order: 0 ext pin, 1 tick, 2..4 capture 1..3, 5..8 compare 1..4,
    // 9 cap4/cmp5, 10 timer overflow, 11 pulse overflow, 12 pulse edge, 13 spi, 14 sci.
    localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
        16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF4, 16'hFFF8, 16'hFFF6,
        16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6,
        16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6};
    localparam logic [15:0] SPECIAL_PAGE_MASK = 16'hBFFF;

    // Mapping from the promote code to the maskable index.
    localparam logic [3:0] PSEL_MAP [16] = '{
        4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h0, 4'h0, 4'h1,
        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

    typedef struct packed {
        logic [4:0] src;
        logic [15:0] vector;
        logic valid;
    } ipvr_grant_t;

    typedef struct packed {
        logic rx_int_en;
        logic tx_empty_int_en;
        logic tx_done_int_en;
        logic idle_line_int_en;
        logic tx_empty_flag;
        logic tx_done_flag;
        logic idle_flag;
    } ipvr_sci_t;
endpackage : ipvr_pkg

// file: ipvr_resolver.sv
/*
 * Interrupt priority vector resolver with its register slave.
 * Assumes peripheral flags arrive synchronous to REF_CLK; mode and request pins are raw.
 */
// Functional notes
// - Serve exactly one source by fixed priority.
// - Six non-maskable sources rank above maskable ones.
// - Fifteen maskable sources in fixed default order.
// - Promoted source rises; others keep order.
// - Promote codes 0000 to 1010 decode as listed.
// - Codes 1011 to 1111 select compares, cap4/cmp5.
// - Reserved code 0101 promotes external pin.
// - Promotion never bypasses global or local mask.
// - Each source keeps its own fixed vector.
// - Promote writes accepted only while masked globally.
// - Maskable sources recognised only when unmasked globally.
// - System vectors; watchdog, clock-fail, nmi gated.
// - Timer vectors qualified by matching local enables.
// - Pulse, spi, sci vectors; sci shares four enables.
// - Latch inverted mode b and mode a.
// - Boot rom visibility only in special modes.
// - Read visibility bit resets set in test.
// - Status read then data read clears rx full.
// - Promote field resets to external pin code.
// - Special modes fetch reset vectors from BFxx.
// - Service sets global mask, nmi sets gate.
// - Requests follow set enabled flags continuously.
module ipvr_resolver (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic NRST,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Pins.
    input wire logic MODE_PIN_A,
    input wire logic MODE_PIN_B,
    input wire logic NMI_REQUEST_PIN_N,
    input wire logic EXT_REQUEST_PIN_N,
    input wire logic CLK_FAIL_EVENT,
    input wire logic WATCHDOG_EVENT,
    // Peripheral flags and enables, synchronous.
    input wire logic [13:0] PERIPH_FLAGS,
    input wire logic [13:0] PERIPH_INT_EN,
    input wire ipvr_pkg::ipvr_sci_t SCI_STATUS,
    input wire logic RX_DATA_LOAD,
    input wire logic [7:0] RX_DATA_IN,
    // Core handshake.
    input wire logic ILLEGAL_OPCODE,
    input wire logic SOFT_TRAP_INSTR,
    input wire logic INSTR_BOUNDARY,
    input wire logic VECTOR_DONE,
    output ipvr_pkg::ipvr_grant_t GRANT,
    output logic GLOBAL_MASK_FLAG,
    output logic NONMASKABLE_GATE_FLAG,
    output logic READ_VIS_BUS,
    output logic BUS_CLK_OUT_EN
);
    import ipvr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_DONE = 3'b100
    } ipvr_state_t;

    logic [1:0] mode_a_sync_reg;
    logic [1:0] mode_b_sync_reg;
    logic [1:0] nmi_sync_reg;
    logic [1:0] ext_sync_reg;
    logic [1:0] cfail_sync_reg;
    logic [1:0] wdog_sync_reg;
    logic strap_done_reg;
    logic [1:0] strap_cnt_reg;
    logic special_mode_latched_reg;
    logic mode_pin_a_latched_reg;
    logic boot_rom_visible_reg;
    logic read_visibility_clk_out_reg;
    logic [3:0] promote_select_reg;
    logic global_mask_reg;
    logic nmi_gate_reg;
    logic clk_fail_detect_en_reg;
    logic watchdog_disable_reg;
    logic reset_pending_reg;
    logic cfail_pending_reg;
    logic wdog_pending_reg;
    logic rx_full_reg;
    logic rx_status_seen_reg;
    logic [7:0] rx_data_reg;
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [15:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    logic read_vis_bus_reg;
    logic bus_clk_out_en_reg;
    ipvr_state_t state_reg;
    ipvr_grant_t grant_reg;
    logic [NUM_SRC-1:0] req;
    logic [NUM_MASKABLE-1:0] mreq;
    logic sci_req;
    logic [3:0] promoted;
    ipvr_grant_t grant_next;
    logic [15:0] ap_addr;
    logic ap_valid;
    logic [7:0] prio_misc_rd;

    // Synchronisers for raw pins and foreign events.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            mode_a_sync_reg <= 2'b00;
            mode_b_sync_reg <= 2'b11;
            nmi_sync_reg <= 2'b11;
            ext_sync_reg <= 2'b11;
            cfail_sync_reg <= 2'b00;
            wdog_sync_reg <= 2'b00;
        end else begin
            mode_a_sync_reg <= {mode_a_sync_reg[0], MODE_PIN_A};
            mode_b_sync_reg <= {mode_b_sync_reg[0], MODE_PIN_B};
            nmi_sync_reg <= {nmi_sync_reg[0], NMI_REQUEST_PIN_N};
            ext_sync_reg <= {ext_sync_reg[0], EXT_REQUEST_PIN_N};
            cfail_sync_reg <= {cfail_sync_reg[0], CLK_FAIL_EVENT};
            wdog_sync_reg <= {wdog_sync_reg[0], WATCHDOG_EVENT};
        end
    end

    // Bus address phase.
    assign ap_valid = HSEL && HREADY && HTRANS[1];
    assign ap_addr = HADDR[15:0];

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 16'h0000;
        end else begin
            dp_valid_reg <= ap_valid;
            dp_write_reg <= HWRITE;
            dp_addr_reg <= ap_addr;
        end
    end

    // Mode straps caught after reset release; register fields set per mode.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            strap_done_reg <= 1'b0;
            strap_cnt_reg <= 2'h0;
            special_mode_latched_reg <= 1'b0;
            mode_pin_a_latched_reg <= 1'b0;
            boot_rom_visible_reg <= 1'b0;
            read_visibility_clk_out_reg <= 1'b0;
        end else if (strap_cnt_reg != STRAP_WAIT) begin
            // Let the mode synchronisers fill with the strap levels first.
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            special_mode_latched_reg <= ~mode_b_sync_reg[1];
            mode_pin_a_latched_reg <= mode_a_sync_reg[1];
            boot_rom_visible_reg <= ~mode_b_sync_reg[1] & ~mode_a_sync_reg[1];
            read_visibility_clk_out_reg <= ~mode_b_sync_reg[1] & mode_a_sync_reg[1];
        end else if (dp_valid_reg && dp_write_reg && dp_addr_reg == PRIO_MISC_OFS) begin
            if (special_mode_latched_reg) begin
                boot_rom_visible_reg <= HWDATA[BOOT_VIS_BIT];
            end
            read_visibility_clk_out_reg <= HWDATA[RDVIS_BIT];
        end
    end

    // Promote field, writable only under global mask.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            promote_select_reg <= PSEL_RESET;
        end else if (dp_valid_reg && dp_write_reg && dp_addr_reg == PRIO_MISC_OFS
                     && global_mask_reg) begin
            promote_select_reg <= HWDATA[PSEL_LSB +: 4];
        end
    end

    // Control bits and mask flags; hardware set wins over software clear.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            global_mask_reg <= 1'b1;
            nmi_gate_reg <= 1'b1;
            clk_fail_detect_en_reg <= 1'b0;
            watchdog_disable_reg <= 1'b0;
        end else begin
            if (dp_valid_reg && dp_write_reg && dp_addr_reg == CORE_CTRL_OFS) begin
                global_mask_reg <= HWDATA[GMASK_BIT];
                nmi_gate_reg <= nmi_gate_reg & HWDATA[XMASK_BIT];
                clk_fail_detect_en_reg <= HWDATA[CLKMON_BIT];
                watchdog_disable_reg <= HWDATA[WDOG_DIS_BIT];
            end
            if (state_reg == ST_HOLD && VECTOR_DONE) begin
                global_mask_reg <= 1'b1;
                if (grant_reg.src == SRC_NMI) begin
                    nmi_gate_reg <= 1'b1;
                end
            end
        end
    end

    // Reset-class requests pending until served.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            reset_pending_reg <= 1'b1;
            cfail_pending_reg <= 1'b0;
            wdog_pending_reg <= 1'b0;
        end else begin
            if (state_reg == ST_HOLD && VECTOR_DONE) begin
                if (grant_reg.src == SRC_RESET) begin
                    reset_pending_reg <= 1'b0;
                end
                if (grant_reg.src == SRC_CLKFAIL) begin
                    cfail_pending_reg <= 1'b0;
                end
                if (grant_reg.src == SRC_WDOG) begin
                    wdog_pending_reg <= 1'b0;
                end
            end
            if (cfail_sync_reg[1] && clk_fail_detect_en_reg) begin
                cfail_pending_reg <= 1'b1;
            end
            if (wdog_sync_reg[1] && !watchdog_disable_reg) begin
                wdog_pending_reg <= 1'b1;
            end
        end
    end

    // Receive-full flag and its two-read clearing sequence.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_full_reg <= 1'b0;
            rx_status_seen_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end else begin
            if (dp_valid_reg && !dp_write_reg && dp_addr_reg == SCI_STAT_OFS) begin
                rx_status_seen_reg <= rx_full_reg;
            end
            if (dp_valid_reg && !dp_write_reg && dp_addr_reg == SCI_DATA_OFS
                && rx_status_seen_reg) begin
                rx_full_reg <= 1'b0;
                rx_status_seen_reg <= 1'b0;
            end
            if (RX_DATA_LOAD) begin
                rx_full_reg <= 1'b1;
                rx_data_reg <= RX_DATA_IN;
            end
        end
    end

    // Request vector from flags and enables.
    assign sci_req = (rx_full_reg && SCI_STATUS.rx_int_en)
                   || (SCI_STATUS.idle_flag && SCI_STATUS.idle_line_int_en)
                   || (SCI_STATUS.tx_empty_flag && SCI_STATUS.tx_empty_int_en)
                   || (SCI_STATUS.tx_done_flag && SCI_STATUS.tx_done_int_en);
    // Flag bit 13 is spare; the serial system request comes from its own status.
    assign mreq = {sci_req, PERIPH_FLAGS[12:0] & PERIPH_INT_EN[12:0], ~ext_sync_reg[1]}
                & {NUM_MASKABLE{~global_mask_reg}};
    assign req = {mreq, SOFT_TRAP_INSTR, ILLEGAL_OPCODE,
                  ~nmi_sync_reg[1] & ~nmi_gate_reg, wdog_pending_reg,
                  cfail_pending_reg, reset_pending_reg};
    assign promoted = PSEL_MAP[promote_select_reg];

    // Fixed priority search with one promoted maskable source.
    always_comb begin
        grant_next = '{src: SRC_NONE, vector: 16'h0000, valid: 1'b0};
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                grant_next.src = 5'(i);
                grant_next.valid = 1'b1;
            end
        end
        if (grant_next.src >= SRC_MASK0 && mreq[promoted]) begin
            grant_next.src = SRC_MASK0 + 5'(promoted);
        end
        if (grant_next.valid) begin
            grant_next.vector = VEC_TABLE[grant_next.src];
            if (special_mode_latched_reg && grant_next.src <= SRC_WDOG) begin
                grant_next.vector = grant_next.vector & SPECIAL_PAGE_MASK;
            end
        end
    end

    // Grant sampled at an instruction boundary and held through the fetch.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_IDLE;
            grant_reg <= '{src: SRC_NONE, vector: 16'h0000, valid: 1'b0};
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (INSTR_BOUNDARY && grant_next.valid && strap_done_reg) begin
                        grant_reg <= grant_next;
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (VECTOR_DONE) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    grant_reg.valid <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data.
    assign prio_misc_rd = {boot_rom_visible_reg & special_mode_latched_reg,
                           special_mode_latched_reg, mode_pin_a_latched_reg,
                           read_visibility_clk_out_reg, promote_select_reg};

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (ap_valid && !HWRITE) begin
            unique case (ap_addr)
                PRIO_MISC_OFS: hrdata_reg <= {24'h00_0000, prio_misc_rd};
                CORE_CTRL_OFS: hrdata_reg <= {28'h000_0000, watchdog_disable_reg,
                                              clk_fail_detect_en_reg, nmi_gate_reg,
                                              global_mask_reg};
                PEND_STAT_OFS: hrdata_reg <= {11'h000, req};
                SCI_STAT_OFS: hrdata_reg <= {26'h000_0000, rx_full_reg, 5'h00};
                SCI_DATA_OFS: hrdata_reg <= {24'h00_0000, rx_data_reg};
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            hrdata_reg <= 32'h0000_0000;
        end
    end

    // Mode-dependent bus visibility and clock pin enables, both registered.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            read_vis_bus_reg <= 1'b0;
            bus_clk_out_en_reg <= 1'b0;
        end else begin
            read_vis_bus_reg <= read_visibility_clk_out_reg & mode_pin_a_latched_reg;
            bus_clk_out_en_reg <= read_visibility_clk_out_reg & ~mode_pin_a_latched_reg;
        end
    end

    // Outputs, all from flip-flops.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    assign HRDATA = hrdata_reg;
    assign GRANT = grant_reg;
    assign GLOBAL_MASK_FLAG = global_mask_reg;
    assign NONMASKABLE_GATE_FLAG = nmi_gate_reg;
    assign READ_VIS_BUS = read_vis_bus_reg;
    assign BUS_CLK_OUT_EN = bus_clk_out_en_reg;
endmodule : ipvr_resolver

// file: ipvr_core_model.sv
/*
 * Behavioural model of the CPU core that asks the resolver for vectors.
 * Assumes serve is called just after a rising edge of REF_CLK.
 */
module ipvr_core_model (
    // Clock.
    input wire logic REF_CLK,
    // Resolver handshake.
    input wire ipvr_pkg::ipvr_grant_t GRANT,
    output logic INSTR_BOUNDARY,
    output logic VECTOR_DONE
);
    timeunit 1ns;
    timeprecision 1ns;
    import ipvr_pkg::*;

    initial begin
        INSTR_BOUNDARY = 1'h0;
        VECTOR_DONE = 1'h0;
    end

    // One boundary, a bounded wait for the grant, a fetch of lat cycles, then done.
    task automatic serve(input int lat, output ipvr_grant_t g);
        int n;
        g = '0;
        repeat (3) @(posedge REF_CLK);
        INSTR_BOUNDARY <= 1'h1;
        @(posedge REF_CLK);
        INSTR_BOUNDARY <= 1'h0;
        for (n = 0; n < 16 && GRANT.valid !== 1'h1; n++) begin
            @(posedge REF_CLK);
        end
        if (GRANT.valid === 1'h1) begin
            g = GRANT;
            repeat (lat) @(posedge REF_CLK);
            VECTOR_DONE <= 1'h1;
            @(posedge REF_CLK);
            VECTOR_DONE <= 1'h0;
        end
        repeat (3) @(posedge REF_CLK);
    endtask : serve
endmodule : ipvr_core_model

// file: ipvr_resolver_chk.sv
/*
 * Assertions on the ports of the interrupt priority vector resolver.
 * Assumes one REF_CLK domain and NRST as its asynchronous reset.
 */
module ipvr_resolver_chk (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic NRST,
    // Bus answer.
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Core handshake and masks.
    input wire logic INSTR_BOUNDARY,
    input wire logic VECTOR_DONE,
    input wire ipvr_pkg::ipvr_grant_t GRANT,
    input wire logic GLOBAL_MASK_FLAG,
    input wire logic NONMASKABLE_GATE_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    import ipvr_pkg::*;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    property p_bus_ok; HREADYOUT && !HRESP; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
    property p_cause; $rose(GRANT.valid) |-> $past(INSTR_BOUNDARY); endproperty
    a_cause: assert property (p_cause) else $error("grant without boundary");
    property p_hold; GRANT.valid && !VECTOR_DONE && !$past(VECTOR_DONE) &&
        !$past(VECTOR_DONE, 2) |=> GRANT.valid && $stable(GRANT); endproperty
    a_hold: assert property (p_hold) else $error("grant changed during fetch");
    property p_drop; GRANT.valid && VECTOR_DONE |-> ##[1:3] !GRANT.valid; endproperty
    a_drop: assert property (p_drop) else $error("grant not released");
    property p_mask; GRANT.valid && VECTOR_DONE |-> ##[1:2] GLOBAL_MASK_FLAG; endproperty
    a_mask: assert property (p_mask) else $error("global mask not set");
    property p_gate; GRANT.valid && VECTOR_DONE && GRANT.src == SRC_NMI
        |-> ##[1:2] NONMASKABLE_GATE_FLAG; endproperty
    a_gate: assert property (p_gate) else $error("gate flag not set");
    property p_vec; GRANT.valid && GRANT.src > SRC_WDOG && GRANT.src <= 5'h14
        |-> GRANT.vector == VEC_TABLE[GRANT.src]; endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");
    property p_sysvec; GRANT.valid && GRANT.src <= SRC_WDOG
        |-> (GRANT.vector | 16'h4000) == VEC_TABLE[GRANT.src]; endproperty
    a_sysvec: assert property (p_sysvec) else $error("wrong reset vector");
    property p_gmask; $rose(GRANT.valid) && GRANT.src >= SRC_MASK0
        |-> !$past(GLOBAL_MASK_FLAG); endproperty
    a_gmask: assert property (p_gmask) else $error("maskable while masked");
    property p_nmask; $rose(GRANT.valid) && GRANT.src == SRC_NMI
        |-> !$past(NONMASKABLE_GATE_FLAG); endproperty
    a_nmask: assert property (p_nmask) else $error("nmi while gated");
    c_nmi: cover property ($rose(GRANT.valid) && GRANT.src == SRC_NMI);
    c_reset: cover property ($rose(GRANT.valid) && GRANT.src == SRC_RESET);
    c_mask: cover property ($rose(GRANT.valid) && GRANT.src >= SRC_MASK0);
endmodule : ipvr_resolver_chk

bind ipvr_resolver ipvr_resolver_chk u_chk (.REF_CLK, .NRST, .HREADYOUT, .HRESP,
    .INSTR_BOUNDARY, .VECTOR_DONE, .GRANT, .GLOBAL_MASK_FLAG, .NONMASKABLE_GATE_FLAG);

// file: ipvr_resolver_tb.sv
/*
 * Self-checking bench of the interrupt priority vector resolver.
 * Assumes the core model and the bound checker of this folder.
 */
module ipvr_resolver_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ipvr_pkg::*;
    logic REF_CLK = 1'h0;
    logic NRST = 1'h0;
    logic HSEL = 1'h0;
    logic [31:0] HADDR = '0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = '0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic MODE_PIN_A = 1'h0;
    logic MODE_PIN_B = 1'h1;
    logic NMI_REQUEST_PIN_N = 1'h1;
    logic EXT_REQUEST_PIN_N = 1'h1;
    logic CLK_FAIL_EVENT = 1'h0;
    logic WATCHDOG_EVENT = 1'h0;
    logic [13:0] PERIPH_FLAGS = '0;
    logic [13:0] PERIPH_INT_EN = '0;
    ipvr_sci_t SCI_STATUS = '0;
    logic RX_DATA_LOAD = 1'h0;
    logic [7:0] RX_DATA_IN = '0;
    logic ILLEGAL_OPCODE = 1'h0;
    logic SOFT_TRAP_INSTR = 1'h0;
    logic INSTR_BOUNDARY;
    logic VECTOR_DONE;
    ipvr_grant_t GRANT;
    logic GLOBAL_MASK_FLAG;
    logic NONMASKABLE_GATE_FLAG;
    logic READ_VIS_BUS;
    logic BUS_CLK_OUT_EN;
    int err_count = 0;
    int compares = 0;

    ipvr_resolver u_dut (.REF_CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .MODE_PIN_A, .MODE_PIN_B,
        .NMI_REQUEST_PIN_N, .EXT_REQUEST_PIN_N, .CLK_FAIL_EVENT, .WATCHDOG_EVENT,
        .PERIPH_FLAGS, .PERIPH_INT_EN, .SCI_STATUS, .RX_DATA_LOAD, .RX_DATA_IN,
        .ILLEGAL_OPCODE, .SOFT_TRAP_INSTR, .INSTR_BOUNDARY, .VECTOR_DONE, .GRANT,
        .GLOBAL_MASK_FLAG, .NONMASKABLE_GATE_FLAG, .READ_VIS_BUS, .BUS_CLK_OUT_EN);
    ipvr_core_model u_core (.REF_CLK, .GRANT, .INSTR_BOUNDARY, .VECTOR_DONE);

    always #50 REF_CLK = ~REF_CLK;

    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (HREADYOUT !== 1'h1 && n < 20);
        if (HREADYOUT !== 1'h1) begin
            err_count++;
            summarize();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
            output logic [31:0] r);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HADDR <= {16'h0000, a};
        HWRITE <= w;
        wait_rdy();
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        r = HRDATA;
    endtask : bus

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, a, d, x);
    endtask : wr

    task automatic rchk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'h0, a, '0, x);
        chk(x, e);
    endtask : rchk

    task automatic gchk(input int lat, input logic [4:0] s, input logic [15:0] v, input logic ok);
        ipvr_grant_t g;
        u_core.serve(lat, g);
        chk({10'h000, g.valid, g.src, g.vector}, ok ? {10'h000, 1'h1, s, v} : '0);
    endtask : gchk

    task automatic do_reset(input logic b, input logic a);
        NRST <= 1'h0;
        MODE_PIN_B <= b;
        MODE_PIN_A <= a;
        repeat (8) @(posedge REF_CLK);
        NRST <= 1'h1;
        repeat (4) @(posedge REF_CLK);
    endtask : do_reset

    initial begin
        logic [1:0] md [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [31:0] pexp [4] = '{32'h0000_00C6, 32'h0000_0076, 32'h0000_0026, 32'h0000_0006};
        logic [15:0] nvec [5] = '{16'hFFFC, 16'hFFFA, 16'hFFF4, 16'hFFF8, 16'hFFF6};
        int idx;
        for (int i = 0; i < 4; i++) begin
            do_reset(md[i][1], md[i][0]);
            rchk(PRIO_MISC_OFS, pexp[i]);
            chk(READ_VIS_BUS, i == 1);
            chk(BUS_CLK_OUT_EN, 1'h0);
            gchk(i * 4, SRC_RESET, i < 2 ? 16'hBFFE : 16'hFFFE, 1'h1);
        end
        PERIPH_FLAGS <= 14'h1FFF;
        PERIPH_INT_EN <= 14'h1FFF;
        EXT_REQUEST_PIN_N <= 1'h0;
        SCI_STATUS <= '{tx_empty_flag: 1'h1, tx_empty_int_en: 1'h1, default: 1'h0};
        gchk(0, 5'h00, 16'h0000, 1'h0);
        wr(PRIO_MISC_OFS, 32'h0000_0093);
        rchk(PRIO_MISC_OFS, 32'h0000_0013);
        chk(BUS_CLK_OUT_EN, 1'h1);
        for (int c = 0; c < 16; c++) begin
            idx = c < 5 ? c + 10 : (c < 7 ? 0 : c - 6);
            wr(PRIO_MISC_OFS, 32'(c));
            wr(CORE_CTRL_OFS, 32'h0000_0000);
            gchk(c % 3, 5'(idx + 6), 16'hFFF2 - 16'(2 * idx), 1'h1);
        end
        wr(CORE_CTRL_OFS, 32'h0000_0000);
        wr(PRIO_MISC_OFS, 32'h0000_0006);
        rchk(PRIO_MISC_OFS, 32'h0000_000F);
        PERIPH_INT_EN[8] <= 1'h0;
        gchk(1, SRC_MASK0, 16'hFFF2, 1'h1);
        wr(PRIO_MISC_OFS, 32'h0000_0006);
        PERIPH_INT_EN[8] <= 1'h1;
        for (int k = 0; k < 15; k++) begin
            wr(CORE_CTRL_OFS, 32'h0000_0000);
            gchk(k % 4, 5'(k + 6), 16'hFFF2 - 16'(2 * k), 1'h1);
            EXT_REQUEST_PIN_N <= 1'h1;
            PERIPH_FLAGS <= 14'h1FFF & (14'h3FFF << k);
            SCI_STATUS.tx_empty_flag <= 1'(k < 14);
        end
        wr(CORE_CTRL_OFS, 32'h0000_0000);
        gchk(0, 5'h00, 16'h0000, 1'h0);
        wr(CORE_CTRL_OFS, 32'h0000_0004);
        EXT_REQUEST_PIN_N <= 1'h0;
        NMI_REQUEST_PIN_N <= 1'h0;
        ILLEGAL_OPCODE <= 1'h1;
        SOFT_TRAP_INSTR <= 1'h1;
        CLK_FAIL_EVENT <= 1'h1;
        WATCHDOG_EVENT <= 1'h1;
        repeat (4) @(posedge REF_CLK);
        CLK_FAIL_EVENT <= 1'h0;
        WATCHDOG_EVENT <= 1'h0;
        for (int s = 1; s < 6; s++) begin
            gchk(s, 5'(s), nvec[s - 1], 1'h1);
            NMI_REQUEST_PIN_N <= 1'(s > 2);
            ILLEGAL_OPCODE <= 1'(s < 4);
            SOFT_TRAP_INSTR <= 1'(s < 5);
        end
        chk(NONMASKABLE_GATE_FLAG, 1'h1);
        wr(CORE_CTRL_OFS, 32'h0000_0008);
        WATCHDOG_EVENT <= 1'h1;
        repeat (4) @(posedge REF_CLK);
        WATCHDOG_EVENT <= 1'h0;
        gchk(0, SRC_MASK0, 16'hFFF2, 1'h1);
        RX_DATA_IN <= 8'hA5;
        RX_DATA_LOAD <= 1'h1;
        @(posedge REF_CLK);
        RX_DATA_LOAD <= 1'h0;
        rchk(SCI_STAT_OFS, 32'h0000_0020);
        rchk(SCI_DATA_OFS, 32'h0000_00A5);
        rchk(SCI_STAT_OFS, 32'h0000_0000);
        rchk(16'h1050, 32'h0000_0000);
        summarize();
    end

    initial begin
        #5_000_000;
        err_count++;
        summarize();
    end
endmodule : ipvr_resolver_tb
